// ---- hdl/acsq_pkg.sv ----
package acsq_pkg;
	// Control sequence
	localparam int unsigned STEP_COUNT       = 30;
	localparam int unsigned STEP_W           = 5;
	localparam int unsigned STEP_WAIT        = 0;
	localparam int unsigned STEP_PACE_EN     = 15;
	// Cycle time of the slow sequencer clock and the system clock
	localparam int unsigned STEP_TIME_NS     = 600;
	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned STEP_DIV         = STEP_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned DIV_W            = 6;
	localparam int unsigned HALF_DIV         = STEP_DIV / 2;
	// Pacing timer
	localparam int unsigned PACE_W           = 16;
	localparam logic [15:0] PACE_FULL        = 16'hFFFF;
	localparam logic [15:0] PACE_RESET       = 16'hFFF6;
	// Register map on the plain port
	localparam logic [3:0]  ADDR_DATA        = 4'h0;
	localparam logic [3:0]  ADDR_ID          = 4'h1;
	localparam logic [3:0]  ADDR_STATUS      = 4'h2;
	localparam logic [3:0]  ADDR_PACE        = 4'h3;
	localparam logic [3:0]  ADDR_CHAN        = 4'h4;
	localparam int unsigned DATA_BUSY_BIT    = 15;
	localparam int unsigned DATA_WAIT_BIT    = 14;
	localparam int unsigned DATA_OVR_BIT     = 13;
	localparam int unsigned DATA_SIGN_BIT    = 12;
	localparam int unsigned STAT_NBUSY_BIT   = 6;
	// Arbitrary identity value
	localparam logic [15:0] ID_VALUE         = 16'h00A5;

	// Control word produced per step
	typedef struct packed {
		logic wait_ind;
		logic pace_stall_enable;
		logic adc_read_n;
		logic adc_write_n;
		logic adc_cd_n;
		logic sample;
		logic latch;
		logic restart;
	} acsq_ctrl_s;

	typedef enum logic [2:0] {
		ACSQ_IDLE = 3'b001,
		ACSQ_GRAB = 3'b010,
		ACSQ_BUSY = 3'b100
	} acsq_busy_e;

	// Control word ROM: step in, word out
	function automatic acsq_ctrl_s acsq_rom(input logic [4:0] s);
		acsq_ctrl_s w;
		w = '{wait_ind:1'b0, pace_stall_enable:1'b0, adc_read_n:1'b1, adc_write_n:1'b1,
			adc_cd_n:1'b1, sample:1'b0, latch:1'b0, restart:1'b0};
		case (s)
			5'd0:  w.wait_ind = 1'b1;
			5'd1:  w.adc_read_n = 1'b0;
			5'd2:
			begin
				w.adc_read_n = 1'b0;
				w.sample = 1'b1;
			end
			5'd3:
			begin
				w.adc_read_n = 1'b0;
				w.adc_cd_n = 1'b0;
			end
			5'd4:
			begin
				w.adc_read_n = 1'b0;
				w.adc_cd_n = 1'b0;
				w.latch = 1'b1;
			end
			5'd5:  w.adc_cd_n = 1'b0;
			5'd7:  w.adc_write_n = 1'b0;
			5'd15: w.pace_stall_enable = 1'b1;
			5'd16: w.adc_cd_n = 1'b0;
			5'd17:
			begin
				w.adc_cd_n = 1'b0;
				w.adc_write_n = 1'b0;
				w.latch = 1'b1;
				w.sample = 1'b1;
			end
			5'd29: w.restart = 1'b1;
			default: w.restart = 1'b0;
		endcase
		return w;
	endfunction : acsq_rom
endpackage : acsq_pkg

// ---- hdl/acsq_sequencer.sv ----
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
// Functional notes
// R01 - Thirty control steps, one per 600 ns step clock; 18 us minimum cycle.
// R02 - Step 0 raises wait; wait with busy low holds the counter.
// R03 - Address removal drops inverted busy at falling edge; count resumes next rise.
// R04 - Step 15 raises pace enable, letting external pace or timer stall.
// R05 - External pace source holding its input keeps counter stopped until released.
// R06 - With pace enable, timer end stalls counter until timer hits FFFF.
// R07 - Leaving wait drops read strobe; next step sample strobe latches MSBs, address.
// R08 - Next step control/data low releases LSBs and loads pace timer.
// R09 - Following step latch strobe clears busy and captures low byte.
// R10 - Read high, control/data high, write low for mode, done by step 7.
// R11 - After pace release: control/data low, then write, latch, sample one step later.
// R12 - Restart after conversion time returns counter to step 0.
// R13 - Card access registers on next rise, gating analog read flag; acknowledge low.
// R14 - Busy low and waiting: address capture rises at next falling edge.
// R15 - Host removes address; flag fall with capture high sets busy, releasing counter.
// R16 - Busy set clears capture next falling edge; busy holds until latch strobe.
// R17 - Busy reads live at data bit 15, inverted at status bit 6.
// R18 - Wait reads at data bit 14; busy and wait are live, not latched.
// R19 - 16-bit pacing timer loads while control/data low, counts after it rises.
// R20 - Timer end is high while counting and falls at FFFF, not rollover.
// R21 - Software programs pace value FFF6 minus rounded (period-18us)/600ns.
// R22 - Pace values FFF7..FFFF wrap before step 15; stall until second end fall.
// R23 - Hard reset or identity write returns to step 0; soft reset clears busy.
// R24 - External pacing needs pace disable low; otherwise disable held high.
// R25 - With no stop condition the counter advances exactly one step per rise.
module acsq_sequencer #(
	parameter int unsigned STEP_DIV = acsq_pkg::STEP_DIV
) (
	input  wire logic        clk_sys_i,               // 100 MHz system clock
	input  wire logic        rst_i,                   // Async hard reset, active high
	input  wire logic [3:0]  reg_addr_i,              // Register address
	input  wire logic [15:0] reg_wdata_i,             // Register write data
	input  wire logic        reg_wr_i,                // Write strobe
	input  wire logic        reg_rd_i,                // Read strobe
	output logic      [15:0] reg_rdata_o,             // Read data, one cycle after strobe
	input  wire logic        card_access_active_i,    // Card addressed on backplane
	input  wire logic        analog_read_i,           // Address bit 6 of the access
	input  wire logic [5:0]  backplane_addr_i,        // Channel/gain address bits
	input  wire logic        external_pace_input_i,   // External pace hold, high stalls
	input  wire logic        internal_pace_disable_i, // Low disables the pacing timer stall
	input  wire logic [3:0]  adc_msb_i,               // First ADC read nibble
	input  wire logic [7:0]  adc_lsb_i,               // Second ADC read byte
	input  wire logic        polarity_n_i,            // Polarity from absolute value stage
	input  wire logic        overrange_n_i,           // Common mode overrange
	output logic             transfer_ack_n_o,        // Data acknowledge, active low
	output logic             adc_read_strobe_n_o,     // ADC read, active low
	output logic             adc_write_strobe_n_o,    // ADC write, active low
	output logic             adc_ctrl_data_strobe_o,  // ADC control(1)/data(0)
	output logic             adc_mode_lines_low_o,    // Drives ADC mode lines low
	output logic             sample_strobe_o,         // Sample/hold in sample state
	output logic             low_byte_latch_strobe_o, // Low byte latch
	output logic             system_clock_o,          // 600 ns clock to ADC
	output logic [5:0]       chan_gain_o,             // Channel/gain buffer
	output logic             busy_o,                  // Busy flag
	output logic             wait_o                   // Wait indicator
);
	typedef struct packed {
		logic [5:0]         div;
		logic [4:0]         step;
		acsq_pkg::acsq_ctrl_s bu;
		acsq_pkg::acsq_busy_e bst;
		logic               acc_sync;
		logic               acc_q;
		logic               ack;
		logic               ar_flag;
		logic               busy;
		logic               grab;
		logic [5:0]         addr_buf;
		logic [5:0]         chan_gain;
		logic [15:0]        pace_reg;
		logic [15:0]        timer;
		logic               timer_end;
		logic [3:0]         msb_buf;
		logic               ovr_buf;
		logic               sign_buf;
		logic [7:0]         lsb_buf;
		logic [15:0]        rdata;
		logic               sclk;
	} acsq_state_s;

	localparam logic [5:0] DIV_LAST = 6'(STEP_DIV - 1);
	localparam logic [5:0] DIV_HALF = 6'(STEP_DIV / 2 - 1);

	acsq_state_s         st_reg;
	acsq_state_s         st_next;
	acsq_pkg::acsq_ctrl_s rom_w;
	logic                rise;
	logic                fall;
	logic                stop;
	logic                soft_rst;

	always_comb
	begin
		st_next  = st_reg;
		rom_w    = acsq_pkg::acsq_rom(st_reg.step);
		rise     = (st_reg.div == DIV_LAST);
		fall     = (st_reg.div == DIV_HALF);
		soft_rst = reg_wr_i && (reg_addr_i == acsq_pkg::ADDR_ID); // [R23]
		// Wait stall and pace stall, as the gate array combined them
		stop = (rom_w.wait_ind && !st_reg.busy) // [R02]
			|| (rom_w.pace_stall_enable && (external_pace_input_i // [R04] [R05]
			|| (internal_pace_disable_i && st_reg.timer_end))); // [R06] [R24]

		// One system step per STEP_DIV fast cycles
		st_next.div = rise ? 6'd0 : 6'(st_reg.div + 6'd1); // [R01]
		if (rise)
			st_next.sclk = 1'b1;
		else if (fall)
			st_next.sclk = 1'b0;

		if (rise)
		begin
			// Counter steps; restart word wraps back to step 0
			if (rom_w.restart || st_reg.step == 5'(acsq_pkg::STEP_COUNT - 1)) // [R12]
				st_next.step = 5'(acsq_pkg::STEP_WAIT);
			else if (!stop)
				st_next.step = 5'(st_reg.step + 5'd1); // [R25] [R03] [R15]

			// Card access flag registered on rise; ack follows one step later
			st_next.acc_sync = card_access_active_i; // [R13]
			st_next.acc_q    = st_reg.acc_sync;
			st_next.ack      = st_reg.acc_sync && card_access_active_i; // [R13]
			if (!card_access_active_i)
			begin
				st_next.acc_sync = 1'b0;
				st_next.ack      = 1'b0;
			end
			st_next.ar_flag = card_access_active_i && analog_read_i; // [R13]

			// Pacing timer loads from the unbuffered strobe, so counting starts at step 6
			if (!rom_w.adc_cd_n)
				st_next.timer = st_reg.pace_reg; // [R19] [R08]
			else
				st_next.timer = 16'(st_reg.timer + 16'd1); // [R22]
			// End low only at full count, high again at wrap
			st_next.timer_end = (st_next.timer != acsq_pkg::PACE_FULL); // [R20]
		end

		if (fall)
		begin
			// Buffered control word half a step after the counter
			st_next.bu = rom_w;
			// Busy machine on falling edges
			case (st_reg.bst)
				acsq_pkg::ACSQ_IDLE:
					if (st_reg.ar_flag && !st_reg.busy && rom_w.wait_ind)
					begin
						st_next.grab     = 1'b1; // [R14]
						st_next.addr_buf = backplane_addr_i; // [R14]
						st_next.bst      = acsq_pkg::ACSQ_GRAB;
					end
				acsq_pkg::ACSQ_GRAB:
					if (!st_reg.ar_flag)
					begin
						st_next.busy = 1'b1; // [R15] [R03]
						st_next.bst  = acsq_pkg::ACSQ_BUSY;
					end
				acsq_pkg::ACSQ_BUSY:
				begin
					st_next.grab = 1'b0; // [R16]
					if (rom_w.latch && st_reg.busy)
					begin
						st_next.busy = 1'b0; // [R09] [R16]
						st_next.bst  = acsq_pkg::ACSQ_IDLE;
					end
				end
				default: st_next.bst = acsq_pkg::ACSQ_IDLE;
			endcase
		end

		// Data capture on buffered strobes at the step rise
		if (rise && st_reg.bu.sample)
		begin
			st_next.msb_buf   = adc_msb_i; // [R07]
			st_next.ovr_buf   = !overrange_n_i; // [R07] [R11]
			st_next.sign_buf  = polarity_n_i; // [R11]
			st_next.chan_gain = st_reg.addr_buf; // [R07]
		end
		if (rise && st_reg.bu.latch && !st_reg.bu.adc_read_n)
			st_next.lsb_buf = adc_lsb_i; // [R09]

		// Register port
		if (reg_wr_i && reg_addr_i == acsq_pkg::ADDR_PACE)
			st_next.pace_reg = reg_wdata_i; // [R21]
		if (reg_rd_i)
			case (reg_addr_i)
				acsq_pkg::ADDR_DATA:
					st_next.rdata = {st_reg.busy, st_reg.bu.wait_ind, // [R17] [R18]
						st_reg.ovr_buf, st_reg.sign_buf, st_reg.msb_buf, st_reg.lsb_buf};
				acsq_pkg::ADDR_ID:     st_next.rdata = acsq_pkg::ID_VALUE;
				acsq_pkg::ADDR_STATUS: st_next.rdata = {9'h000, !st_reg.busy, 6'h00}; // [R17]
				acsq_pkg::ADDR_PACE:   st_next.rdata = st_reg.pace_reg;
				acsq_pkg::ADDR_CHAN:   st_next.rdata = {10'h000, st_reg.chan_gain};
				default:               st_next.rdata = 16'h0000;
			endcase
		else
			st_next.rdata = 16'h0000;

		if (soft_rst)
		begin
			st_next.step = 5'(acsq_pkg::STEP_WAIT); // [R23]
			st_next.busy = 1'b0;
			st_next.grab = 1'b0;
			st_next.bst  = acsq_pkg::ACSQ_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_reg           <= '0;
			st_reg.bu        <= acsq_pkg::acsq_rom(5'd0);
			st_reg.bst       <= acsq_pkg::ACSQ_IDLE;
			st_reg.pace_reg  <= acsq_pkg::PACE_RESET;
			st_reg.timer     <= acsq_pkg::PACE_RESET;
			st_reg.timer_end <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	assign reg_rdata_o             = st_reg.rdata;
	assign transfer_ack_n_o        = !st_reg.ack;
	assign adc_read_strobe_n_o     = st_reg.bu.adc_read_n;
	assign adc_write_strobe_n_o    = st_reg.bu.adc_write_n;
	assign adc_ctrl_data_strobe_o  = st_reg.bu.adc_cd_n;
	assign adc_mode_lines_low_o    = st_reg.bu.adc_read_n; // [R10]
	assign sample_strobe_o         = st_reg.bu.sample;
	assign low_byte_latch_strobe_o = st_reg.bu.latch;
	assign system_clock_o          = st_reg.sclk;
	assign chan_gain_o             = st_reg.chan_gain;
	assign busy_o                  = st_reg.busy;
	assign wait_o                  = st_reg.bu.wait_ind;
endmodule : acsq_sequencer

// ---- bench/acsq_seq_chk.sv ----
`timescale 1ns/1ps
module acsq_seq_chk #(
	parameter int unsigned STEP_DIV = 60
) (
	input wire logic        clk_sys_i,               // Clock
	input wire logic        rst_i,                   // Reset
	input wire logic [3:0]  reg_addr_i,              // Register address
	input wire logic        reg_wr_i,                // Write strobe
	input wire logic        reg_rd_i,                // Read strobe
	input wire logic [15:0] reg_rdata_o,             // Read data
	input wire logic        card_access_active_i,    // Card addressed
	input wire logic        analog_read_i,           // Analog read flag
	input wire logic        transfer_ack_n_o,        // Acknowledge
	input wire logic        adc_read_strobe_n_o,     // ADC read
	input wire logic        adc_ctrl_data_strobe_o,  // ADC control/data
	input wire logic        sample_strobe_o,         // Sample
	input wire logic        low_byte_latch_strobe_o, // Latch
	input wire logic        busy_o,                  // Busy
	input wire logic        wait_o                   // Wait
);
	localparam int S = STEP_DIV;
	localparam int S1 = STEP_DIV + 1;
	localparam int S2 = 2 * STEP_DIV + 2;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_read_go;
		$fell(adc_read_strobe_n_o);
	endsequence
	sequence s_sample_go;
		$rose(sample_strobe_o) && !adc_read_strobe_n_o;
	endsequence
	a_rest_quiet: assert property ($rose(wait_o) |-> adc_read_strobe_n_o && !sample_strobe_o)
		else $error("strobe active on entry to wait");
	a_sample_next: assert property (s_read_go |-> !sample_strobe_o ##[1:S1] sample_strobe_o)
		else $error("sample did not follow read");
	a_cd_next: assert property (s_sample_go |-> ##[1:S1] !adc_ctrl_data_strobe_o)
		else $error("control/data did not follow sample");
	a_latch_clears: assert property ($rose(low_byte_latch_strobe_o) && !adc_read_strobe_n_o
		|-> ##[0:S] !busy_o)
		else $error("latch did not clear busy");
	a_busy_held: assert property ($fell(busy_o) |-> low_byte_latch_strobe_o ||
		$past(low_byte_latch_strobe_o) || $past(reg_wr_i) || $past(reg_wr_i, 2))
		else $error("busy dropped without latch");
	a_data_live: assert property (reg_rd_i && reg_addr_i == 4'h0
		|=> reg_rdata_o[15:14] == $past({busy_o, wait_o}))
		else $error("data bits 15:14 not live");
	a_stat_nbusy: assert property (reg_rd_i && reg_addr_i == 4'h2
		|=> reg_rdata_o[6] == !$past(busy_o))
		else $error("status bit 6 not inverted busy");
	a_ack_cause: assert property ($fell(transfer_ack_n_o) |-> card_access_active_i)
		else $error("acknowledge without access");
	a_ack_delay: assert property ($rose(card_access_active_i)
		|-> transfer_ack_n_o[*2] ##[1:S2] !transfer_ack_n_o)
		else $error("acknowledge timing wrong");
	a_busy_set: assert property ($fell(card_access_active_i) && $past(analog_read_i)
		&& wait_o && !busy_o |-> ##[1:S2] busy_o)
		else $error("busy not set after read");
	a_resume_wait: assert property ($rose(busy_o) && wait_o |-> ##[1:S1] !wait_o)
		else $error("counter did not resume");
endmodule : acsq_seq_chk

// ---- bench/acsq_host_model.sv ----
`timescale 1ns/1ps
module acsq_host_model (
	input  wire logic  clk_sys_i, // Clock
	input  wire logic  ack_n_i,   // Card acknowledge
	output logic       access_o,  // Card addressed
	output logic       analog_o,  // Address bit 6
	output logic [5:0] addr_o     // Channel/gain bits
);
	initial
	begin
		access_o = 1'b0;
		analog_o = 1'b0;
		addr_o = 6'h3f;
	end
	task automatic analog_read(input logic [5:0] a, output logic ok);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		access_o <= 1'b1;
		analog_o <= 1'b1;
		addr_o <= a;
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (ack_n_i !== 1'b0 && n < 1000);
		ok = (n < 1000);
		// Released address shows its inverse so stale values cannot pass
		access_o <= 1'b0;
		analog_o <= 1'b0;
		addr_o <= ~a;
	endtask : analog_read
endmodule : acsq_host_model

// ---- bench/adc_conversion_sequencer_test.sv ----
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
	localparam int SD = 4;
	logic        clk_sys_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, ok;
	logic [3:0]  reg_addr_i = '0, msb = '0;
	logic [15:0] reg_wdata_i = '0, reg_rdata_o, rd;
	logic        acc, ana, ext = 0, pdis = 1, ack_n, wt, busy;
	logic [5:0]  addr, chan, a;
	logic [7:0]  lsb = '0;
	int          n_errors = 0, n_tests = 0, n, k;
	always #5 clk_sys_i = ~clk_sys_i;
	acsq_sequencer #(.STEP_DIV(SD)) dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .card_access_active_i(acc),
		.analog_read_i(ana), .backplane_addr_i(addr), .external_pace_input_i(ext),
		.internal_pace_disable_i(pdis), .adc_msb_i(msb), .adc_lsb_i(lsb),
		.polarity_n_i(1'b1), .overrange_n_i(1'b1), .transfer_ack_n_o(ack_n),
		.adc_read_strobe_n_o(), .adc_write_strobe_n_o(), .adc_ctrl_data_strobe_o(),
		.adc_mode_lines_low_o(), .sample_strobe_o(), .low_byte_latch_strobe_o(),
		.system_clock_o(), .chan_gain_o(chan), .busy_o(busy), .wait_o(wt));
	acsq_host_model host_u (.clk_sys_i(clk_sys_i), .ack_n_i(ack_n), .access_o(acc),
		.analog_o(ana), .addr_o(addr));
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic reg_io(input logic w, input logic [3:0] ad, input logic [15:0] d);
		@(posedge clk_sys_i);
		reg_wr_i <= w;
		reg_rd_i <= !w;
		reg_addr_i <= ad;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		#1 rd = reg_rdata_o;
	endtask : reg_io
	task automatic wait_lvl(input logic v, input int lim, output int cnt);
		cnt = 0;
		while (wt !== v && cnt < lim)
		begin
			@(posedge clk_sys_i);
			cnt++;
		end
		#1;
	endtask : wait_lvl
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#400_000;
		n_errors++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(81251));
		repeat (3) @(posedge clk_sys_i);
		check("rst", {wt, busy, ack_n}, 3'b101);
		rst_i <= 1'b0;
		reg_io(0, acsq_pkg::ADDR_PACE, 0);
		check("pace", rd, 16'hfff6);
		reg_io(0, acsq_pkg::ADDR_STATUS, 0);
		check("nbusy", rd[6], 1);
		reg_io(0, acsq_pkg::ADDR_DATA, 0);
		check("busywait", rd[15:14], 2'b01);
		reg_io(0, 4'hf, 0);
		check("unmapped", rd, 0);
		$display("test registers done");
		for (int i = 0; i < 4; i++)
		begin
			k = (i == 0) ? 0 : $urandom_range(1, 6);
			a = 6'($urandom);
			msb <= 4'($urandom);
			lsb <= 8'($urandom);
			reg_io(1, acsq_pkg::ADDR_PACE, 16'hfff6 - 16'(k));
			host_u.analog_read(a, ok);
			check("ack", ok, 1);
			wait_lvl(0, 500, n);
			check("busy", busy, 1);
			wait_lvl(1, 5000, n);
			check("cycle", n, (29 + k) * SD);
			check("chan", chan, a);
			reg_io(0, acsq_pkg::ADDR_DATA, 0);
			check("data", {rd[15], rd[11:0]}, {1'b0, msb, lsb});
			$display("test timer pace %0d done", k);
		end
		ext <= 1'b1;
		pdis <= 1'b0;
		host_u.analog_read(6'h15, ok);
		repeat (60 * SD) @(posedge clk_sys_i);
		check("held", wt, 0);
		ext <= 1'b0;
		wait_lvl(1, 20 * SD, n);
		check("resume", {wt, 1'(n > 12 * SD)}, 2'b11);
		pdis <= 1'b1;
		$display("test external pace done");
		host_u.analog_read(6'h2a, ok);
		wait_lvl(0, 500, n);
		reg_io(0, acsq_pkg::ADDR_DATA, 0);
		check("busyread", rd[15:14], 2'b10);
		reg_io(1, acsq_pkg::ADDR_ID, 16'($urandom));
		// Wait output is the buffered word, so it follows at the next falling edge, up to a step later
		repeat (SD) @(posedge clk_sys_i);
		#1;
		check("soft", {wt, busy}, 2'b10);
		$display("test soft reset done");
		report_and_stop();
	end
endmodule : adc_conversion_sequencer_test
bind acsq_sequencer acsq_seq_chk #(.STEP_DIV(STEP_DIV)) chk_u (.*);
